// ---- bcf_frame_handler.sv ----
// module: command frame receiver, executor handshake and reply sender
//
// Overview of operation
// - stays receiving; transmits only a reply to a received command.
// - reply is sent after the executor reports completion, or at once on a bad sum.
// - command core is code, type, selector and four value bytes.
// - serial frame adds address byte first and checksum byte last.
// - serial order: address, code, type, selector, value MSB first, sum.
// - checksum is 8-bit wrapping sum of prior bytes; device verifies.
// - CAN frames carry no address or checksum byte.
// - reply order: reply addr, module addr, status, code, value, sum.
// - reply ends with 8-bit wrapping sum of the other reply bytes.
// - CAN replies carry no address or checksum byte.
// - status 100 when executed, 101 when stored to program memory.
// - error statuses 1 to 6 reported when a command fails.
`timescale 1ns/1ps
module bcf_frame_handler (
  input  wire logic                    i_clk,        // 125 MHz clock
  input  wire logic                    i_nrst,       // async reset, low
  input  wire logic                    i_can_mode,   // 1: CAN framing
  input  wire logic [7:0]              i_mod_addr,   // own module address
  input  wire logic [7:0]              i_reply_addr, // reply address byte
  input  wire logic                    i_rx_valid,   // received byte strobe
  input  wire logic [7:0]              i_rx_byte,    // received byte
  input  wire logic                    i_tx_ready,   // link takes tx byte
  input  wire logic                    i_exe_done,   // executor finished
  input  wire bcf_pkg::bcf_result_type i_exe_res,    // status and value
  output logic                         o_tx_valid,   // tx byte offered
  output logic [7:0]                   o_tx_byte,    // tx byte
  output logic                         o_tx_last,    // last reply byte
  output logic                         o_exe_start,  // one-cycle start
  output bcf_pkg::bcf_cmd_type         o_exe_cmd,    // command to execute
  output logic                         o_busy        // not receiving
);

  bcf_pkg::bcf_state_type state;
  logic [3:0]             rx_idx;
  logic [3:0]             tx_idx;
  logic [7:0]             rx_sum;
  logic                   addr_ok;
  logic [7:0]             rx_buf [0:bcf_pkg::CORE_BYTES-1];
  bcf_pkg::bcf_result_type res;
  logic [7:0]             tx_sum;
  logic                   frame_end;
  logic                   sum_ok;
  logic [3:0]             rx_last;
  logic [3:0]             tx_last_idx;
  logic [7:0]             next_tx_byte;

  // serial frames are 9 bytes, CAN frames only the 7-byte core
  assign rx_last     = i_can_mode ? bcf_pkg::IDX_CAN_LAST
                                  : bcf_pkg::IDX_LAST;
  // can replies drop both address slots and the sum slot
  assign tx_last_idx = i_can_mode ? bcf_pkg::IDX_CAN_TX_LAST
                                  : bcf_pkg::IDX_LAST;
  assign frame_end   = (state == bcf_pkg::ST_RECV) && i_rx_valid
                       && (rx_idx == rx_last);
  // can relies on the link crc, so there is no sum byte to check
  assign sum_ok      = i_can_mode || (rx_sum == i_rx_byte);

  // receive position and running sum
  // bytes arriving while busy are dropped; the host must wait
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rx_idx  <= bcf_pkg::RESET_IDX;
      rx_sum  <= bcf_pkg::RESET_BYTE;
      addr_ok <= 1'b0;
    end else if (state == bcf_pkg::ST_RECV && i_rx_valid) begin
      rx_sum <= rx_sum + i_rx_byte;
      // address judged on byte 0, applied when the frame ends
      if (!i_can_mode && rx_idx == bcf_pkg::RESET_IDX) begin
        addr_ok <= (i_rx_byte == i_mod_addr);
      end else if (i_can_mode && rx_idx == bcf_pkg::RESET_IDX) begin
        addr_ok <= 1'b1;
      end
      if (frame_end) begin
        rx_idx <= bcf_pkg::RESET_IDX;
        rx_sum <= bcf_pkg::RESET_BYTE;
      end else begin
        rx_idx <= rx_idx + 4'h1;
      end
    end
  end

  // core bytes land in order: code, type, selector, value msb first
  // loaded only while receiving, so the code survives into the reply
  genvar g;
  generate
    for (g = 0; g < bcf_pkg::CORE_BYTES; g++) begin : g_core
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          rx_buf[g] <= bcf_pkg::RESET_BYTE;
        end else if (state == bcf_pkg::ST_RECV && i_rx_valid
                     && rx_idx == (i_can_mode ? 4'(g) : 4'(g + 1))) begin
          rx_buf[g] <= i_rx_byte;
        end
      end
    end
  endgenerate

  // sequencing: receive, execute, wait for done, reply
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= bcf_pkg::ST_RECV;
    end else begin
      case (state)
        bcf_pkg::ST_RECV: begin
          // frames for another module leave the state untouched
          if (frame_end && (addr_ok || i_can_mode)) begin
            if (sum_ok)
              state <= bcf_pkg::ST_EXEC;
            else
              state <= bcf_pkg::ST_REPLY;
          end
        end
        bcf_pkg::ST_EXEC: begin
          state <= bcf_pkg::ST_WAIT;
        end
        bcf_pkg::ST_WAIT: begin
          if (i_exe_done)
            state <= bcf_pkg::ST_REPLY;
        end
        bcf_pkg::ST_REPLY: begin
          if (o_tx_valid && i_tx_ready && o_tx_last)
            state <= bcf_pkg::ST_RECV;
        end
        default: state <= bcf_pkg::ST_RECV;
      endcase
    end
  end

  // executor strobe and command, one cycle after the frame is accepted
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_exe_start <= 1'b0;
      o_exe_cmd   <= '0;
    end else begin
      o_exe_start <= (state == bcf_pkg::ST_EXEC);
      if (state == bcf_pkg::ST_EXEC)
        o_exe_cmd <= {rx_buf[0], rx_buf[1], rx_buf[2], rx_buf[3],
                      rx_buf[4], rx_buf[5], rx_buf[6]};
    end
  end

  // reply status: a bad sum is answered without running the executor
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      res <= '0;
    end else if (frame_end && (addr_ok || i_can_mode) && !sum_ok) begin
      res.status <= bcf_pkg::ST_BAD_SUM;
      res.value  <= '0;
    end else if (state == bcf_pkg::ST_WAIT && i_exe_done) begin
      res <= i_exe_res;
    end
  end

  // reply byte selection
  // can replies skip the two address slots
  always_comb begin
    logic [3:0] k;
    k = i_can_mode ? tx_idx + 4'h2 : tx_idx;
    case (k)
      4'h0:    next_tx_byte = i_reply_addr;
      4'h1:    next_tx_byte = i_mod_addr;
      4'h2:    next_tx_byte = res.status;
      // echo the received code, also when execution was skipped
      4'h3:    next_tx_byte = rx_buf[0];
      4'h4:    next_tx_byte = res.value[31:24];
      4'h5:    next_tx_byte = res.value[23:16];
      4'h6:    next_tx_byte = res.value[15:8];
      4'h7:    next_tx_byte = res.value[7:0];
      default: next_tx_byte = tx_sum;
    endcase
  end

  // reply transmitter, only active after a received command
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tx_idx     <= bcf_pkg::RESET_IDX;
      tx_sum     <= bcf_pkg::RESET_BYTE;
      o_tx_valid <= 1'b0;
      o_tx_byte  <= bcf_pkg::RESET_BYTE;
      o_tx_last  <= 1'b0;
    end else if (state == bcf_pkg::ST_REPLY) begin
      // hold the byte until the link takes it
      if (!o_tx_valid || i_tx_ready) begin
        if (o_tx_valid && o_tx_last) begin
          o_tx_valid <= 1'b0;
          o_tx_last  <= 1'b0;
          tx_idx     <= bcf_pkg::RESET_IDX;
          tx_sum     <= bcf_pkg::RESET_BYTE;
        end else begin
          o_tx_valid <= 1'b1;
          o_tx_byte  <= next_tx_byte;
          o_tx_last  <= (tx_idx == tx_last_idx);
          tx_sum     <= tx_sum + next_tx_byte;
          tx_idx     <= tx_idx + 4'h1;
        end
      end
    end else begin
      // outside a reply the transmitter sits idle and cleared
      o_tx_valid <= 1'b0;
      o_tx_last  <= 1'b0;
      tx_idx     <= bcf_pkg::RESET_IDX;
      tx_sum     <= bcf_pkg::RESET_BYTE;
    end
  end

  // one cycle behind the state machine
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= (state != bcf_pkg::ST_RECV);
    end
  end

endmodule // bcf_frame_handler

// ---- bcf_pkg.sv ----
// package: constants and types for the binary command frame handler
package bcf_pkg;
  localparam int unsigned FRAME_BYTES  = 9;
  localparam int unsigned CORE_BYTES   = 7;
  localparam logic [3:0]  IDX_LAST     = 4'h8;
  localparam logic [3:0]  IDX_CAN_LAST = 4'h6;
  localparam logic [3:0]  IDX_CAN_TX_LAST = 4'h5;
  localparam logic [7:0]  ST_OK        = 8'h64;  // 100
  localparam logic [7:0]  ST_STORED    = 8'h65;  // 101
  localparam logic [7:0]  ST_BAD_SUM   = 8'h01;
  localparam logic [7:0]  ST_BAD_CMD   = 8'h02;
  localparam logic [7:0]  ST_BAD_TYPE  = 8'h03;
  localparam logic [7:0]  ST_BAD_VALUE = 8'h04;
  localparam logic [7:0]  ST_LOCKED    = 8'h05;
  localparam logic [7:0]  ST_NOT_AVAIL = 8'h06;
  localparam logic [7:0]  RESET_BYTE   = 8'h00;
  localparam logic [3:0]  RESET_IDX    = 4'h0;

  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  typ;
    logic [7:0]  bank;
    logic [31:0] value;
  } bcf_cmd_type;

  typedef struct packed {
    logic [7:0]  status;
    logic [31:0] value;
  } bcf_result_type;

  typedef enum logic [3:0] {
    ST_RECV  = 4'b0001,
    ST_EXEC  = 4'b0010,
    ST_WAIT  = 4'b0100,
    ST_REPLY = 4'b1000
  } bcf_state_type;
endpackage

// ---- bcf_checker.sv ----
// checker: timing at the frame handler ports
`timescale 1ns/1ps
module bcf_checker (
  input wire logic       i_clk,       // clock
  input wire logic       i_nrst,      // reset
  input wire logic       i_can_mode,  // can
  input wire logic       i_tx_ready,  // ready
  input wire logic       i_exe_done,  // done
  input wire logic       o_tx_valid,  // valid
  input wire logic [7:0] o_tx_byte,   // byte
  input wire logic       o_tx_last,   // last
  input wire logic       o_exe_start, // start
  input wire logic       o_busy       // busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic       wt;
  logic [3:0] idx;
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst) wt <= 1'b0;
    else if (o_exe_start || i_exe_done) wt <= o_exe_start;
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst) idx <= 4'h0;
    else if (o_tx_valid && i_tx_ready) idx <= o_tx_last ? 4'h0 : idx + 4'h1;
  property p_quiet; wt |-> !o_tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("early reply");
  property p_ans; wt && i_exe_done |-> ##2 o_tx_valid; endproperty
  a_ans: assert property (p_ans) else $error("late reply");
  property p_hold;
    o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte);
  endproperty
  a_hold: assert property (p_hold) else $error("byte dropped");
  property p_busy; o_tx_valid |-> o_busy; endproperty
  a_busy: assert property (p_busy) else $error("send while idle");
  property p_pulse; o_exe_start |=> !o_exe_start; endproperty
  a_pulse: assert property (p_pulse) else $error("long start");
  property p_len;
    o_tx_valid && o_tx_last
      |-> idx == (i_can_mode ? bcf_pkg::IDX_CAN_TX_LAST : bcf_pkg::IDX_LAST);
  endproperty
  a_len: assert property (p_len) else $error("reply length");
  property p_end; o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid;
  endproperty
  a_end: assert property (p_end) else $error("extra byte");
  property p_idle; o_exe_start |-> !o_tx_valid && !wt; endproperty
  a_idle: assert property (p_idle) else $error("start overlap");
endmodule // bcf_checker
bind bcf_frame_handler bcf_checker u_chk (.i_clk, .i_nrst, .i_can_mode,
  .i_tx_ready, .i_exe_done, .o_tx_valid, .o_tx_byte, .o_tx_last,
  .o_exe_start, .o_busy);

// ---- bcf_host.sv ----
// host model: sends command frames, collects reply bytes
`timescale 1ns/1ps
module bcf_host (
  input  wire logic       i_clk,  // clock
  input  wire logic       i_slow, // stall reader
  input  wire logic       i_tx_v, // byte offered
  input  wire logic [7:0] i_tx_b, // offered byte
  output logic            o_rx_v, // byte strobe
  output logic [7:0]      o_rx_b, // byte
  output logic            o_rdy   // reader ready
);
  logic [7:0] rep [$];
  initial {o_rx_v, o_rx_b, o_rdy} = 10'h000;
  always @(posedge i_clk) begin
    if (i_tx_v && o_rdy) rep.push_back(i_tx_b);
    o_rdy <= !i_slow || !o_rdy;
  end
  task automatic send(input logic [63:0] f, input logic c,
                      input logic [7:0] s);
    for (int i = c; i < 8; i++) begin
      @(posedge i_clk);
      o_rx_v <= 1'b1;
      o_rx_b <= f[63-8*i-:8];
      s = s + f[63-8*i-:8];
    end
    if (!c) begin
      @(posedge i_clk);
      o_rx_b <= s;
    end
    @(posedge i_clk);
    o_rx_v <= 1'b0;
    o_rx_b <= ~o_rx_b;
  endtask
endmodule // bcf_host

// ---- binary_command_frame_handler_test.sv ----
// testbench: frame handler against the host model
`timescale 1ns/1ps
module binary_command_frame_handler_test;
  localparam logic [7:0] MA = 8'h05;
  localparam logic [7:0] RA = 8'h02;
  logic                    i_clk = 1'b0, i_nrst = 1'b0, can = 1'b0;
  logic                    stall = 1'b0, done = 1'b0;
  logic                    rx_v, tx_v, tx_l, start, busy, rdy;
  logic [7:0]              rx_b, tx_b;
  bcf_pkg::bcf_result_type res = '0;
  bcf_pkg::bcf_cmd_type    cmd;
  int                      miscompares = 0, cmp_count = 0, cyc = 0, ns = 0;
  logic [47:0] rows [8] = '{ // cmd, status, value
    {8'h01, bcf_pkg::ST_OK, 32'h8000_0001},
    {8'h02, bcf_pkg::ST_STORED, 32'h0},
    {8'h03, bcf_pkg::ST_BAD_SUM, 32'h1},
    {8'h04, bcf_pkg::ST_BAD_CMD, 32'hff},
    {8'h05, bcf_pkg::ST_BAD_TYPE, 32'h7f},
    {8'h06, bcf_pkg::ST_BAD_VALUE, 32'h2},
    {8'h09, bcf_pkg::ST_LOCKED, 32'h3},
    {8'hff, bcf_pkg::ST_NOT_AVAIL, 32'hfe}};
  bcf_frame_handler dut (.i_clk, .i_nrst, .i_can_mode(can), .i_mod_addr(MA),
    .i_reply_addr(RA), .i_rx_valid(rx_v), .i_rx_byte(rx_b), .i_tx_ready(rdy),
    .i_exe_done(done), .i_exe_res(res), .o_tx_valid(tx_v), .o_tx_byte(tx_b),
    .o_tx_last(tx_l), .o_exe_start(start), .o_exe_cmd(cmd), .o_busy(busy));
  bcf_host host (.i_clk, .i_slow(stall), .i_tx_v(tx_v), .i_tx_b(tx_b),
    .o_rx_v(rx_v), .o_rx_b(rx_b), .o_rdy(rdy));
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_clk) begin
    ns <= ns + start;
    if (++cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic run(input logic [63:0] f, input logic [7:0] sk, st,
                     input logic [31:0] v, input logic [7:0] ec);
    logic [7:0] e [9];
    host.rep.delete();
    host.send(f, can, sk);
    if (sk == 8'h00) begin
      for (int t = 0; t < 20 && !start; t++) @(negedge i_clk);
      chk(cmd, f[55:0]);
      repeat (st[0] + 1) @(posedge i_clk);
      done <= 1'b1;
      res <= {st, v};
      @(posedge i_clk);
      done <= 1'b0;
    end
    e = '{RA, MA, st, ec, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    for (int i = 0; i < 8; i++) e[8] += e[i];
    for (int t = 0; t < 99 && host.rep.size() < 9 - 3 * can; t++)
      @(negedge i_clk);
    chk(host.rep.size(), 9 - 3 * can);
    for (int i = 0; i < 9 - 3 * can; i++)
      chk(host.rep[i], e[i + 2 * can]);
  endtask
  initial begin
    logic [47:0] r;
    int n0;
    repeat (3) @(posedge i_clk);
    chk({tx_v, tx_l, start, busy}, 4'h0);
    i_nrst <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      stall <= i[0];
      run({MA, r[47:40], 8'h01, 8'(i), r[31:0]}, 8'h00, r[39:32], ~r[31:0],
          r[47:40]);
    end
    n0 = ns;
    run({MA, 56'h07_01_00_00_00_00_09}, 8'h01, bcf_pkg::ST_BAD_SUM, 32'h0,
        8'h07);
    host.send({MA + 8'h01, 56'h01_00_00_00_00_00_01}, 1'b0, 8'h00);
    repeat (30) @(negedge i_clk);
    chk(host.rep.size() + ns, 9 + n0);
    @(posedge i_clk);
    can <= 1'b1;
    @(negedge i_clk);
    run({8'h00, 56'h05_02_00_12_34_56_78}, 8'h00, bcf_pkg::ST_OK, 32'h1,
        8'h05);
    close_out();
  end
endmodule // binary_command_frame_handler_test
